// ---- hdl/npmc_top.v ----
`timescale 1ns/10ps
`include "npmc_defines.vh"
module npmc_top (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire [7:0]  chanPulse,
  input  wire        measStart,
  input  wire [1:0]  gateSel,
  input  wire [2:0]  predelaySel,
  input  wire        dumpReq,
  output wire [31:0] outData,
  output wire        outValid,
  input  wire        outReady,
  output wire        overflowFlag,
  output wire        dumpBusy
);

  localparam [1:0] ST_IDLE    = 2'h1;
  localparam [1:0] ST_DUMP    = 2'h2;
  localparam integer PRED_STEP_I = `NPMC_PREDELAY_STEP_TICKS;
  localparam integer GATE_HALF_I = `NPMC_DIE_AWAY_TICKS / 2;
  localparam integer TICK_LAST_I = `NPMC_TICK_CYCLES - 1;
  localparam [5:0]   PRED_STEP   = PRED_STEP_I[5:0];
  localparam [6:0]   GATE_HALF   = GATE_HALF_I[6:0];
  localparam [4:0]   TICK_LAST   = TICK_LAST_I[4:0];

  // One loop variable per process, so none is driven from two places
  integer i;
  integer hIdx;
  integer bIdx;

  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  reg  [7:0] sync1_reg;
  reg  [7:0] sync2_reg;
  reg  [7:0] sync3_reg;
  reg  [7:0] level_reg;
  wire [7:0] agree;
  wire [7:0] riseEvt;
  wire [7:0] level_next;

  assign agree      = ~(sync2_reg ^ sync3_reg);
  assign riseEvt    = agree & sync2_reg & ~level_reg;
  assign level_next = (level_reg & ~agree) | (sync2_reg & agree);

  // Low time of two cycles is enough for a new edge, well inside 15 ns
  always @(posedge ref_clk) begin
    if (rst) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      sync3_reg <= 8'h00;
      level_reg <= 8'h00;
    end else begin
      sync1_reg <= chanPulse;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      level_reg <= level_next;
    end
  end

  // ----------------------------------------
  // Merger: one pulse per clock into the queue
  // ----------------------------------------
  reg  [7:0] pend_reg;
  reg  [2:0] grantIdx;
  reg        ovf_reg;
  wire [7:0] lowBit;
  wire       mergeValid;
  wire       inReady;
  wire       mergePush;
  wire [7:0] pend_next;
  wire       ovfSet;

  assign lowBit     = pend_reg & (~pend_reg + 8'h01);
  assign mergeValid = |pend_reg;
  assign mergePush  = mergeValid & inReady;
  // A new edge on a channel wins over the grant that clears it
  assign pend_next  = (pend_reg & ~(mergePush ? lowBit : 8'h00)) | riseEvt;
  assign ovfSet     = (mergeValid & ~inReady) | (|(riseEvt & pend_reg & ~lowBit));

  always @* begin
    grantIdx = 3'h0;
    for (i = `NPMC_NUM_CHAN - 1; i >= 0; i = i - 1) begin
      if (lowBit[i]) begin
        grantIdx = i[2:0];
      end
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      pend_reg <= 8'h00;
      ovf_reg  <= 1'b0;
    end else begin
      pend_reg <= measStart ? riseEvt : pend_next;
      ovf_reg  <= ovfSet | (ovf_reg & ~measStart);
    end
  end

  // ----------------------------------------
  // Input queue and history tick
  // ----------------------------------------
  reg  [4:0] phase_reg;
  wire       endTick;
  wire       queueValid;
  wire       queuePop;

  assign endTick  = (phase_reg == TICK_LAST);
  // Draining stalls on the tick boundary, so bursts really back up here
  assign queuePop = queueValid & ~endTick;

  npmc_fifo #(
    .WIDTH (3),
    .DEPTH (`NPMC_IN_DEPTH),
    .CW    (5)
  ) inQueue (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clr      (measStart),
    .inData   (grantIdx),
    .inValid  (mergeValid),
    .inReady  (inReady),
    .outData  (),
    .outValid (queueValid),
    .outReady (~endTick)
  );

  // ----------------------------------------
  // Gate geometry latched per measurement
  // ----------------------------------------
  reg  [1:0] gateSelLat_reg;
  reg  [2:0] predSelLat_reg;
  wire [5:0] predTicks;
  wire [6:0] gateTicks;

  assign predTicks = PRED_STEP * ({3'h0, predSelLat_reg} + 6'h01);
  assign gateTicks = GATE_HALF * ({5'h00, gateSelLat_reg} + 7'h01);

  // ----------------------------------------
  // Pulse history and running gate sums
  // ----------------------------------------
  reg  [4:0]  histBuf [0:`NPMC_HIST_DEPTH-1];
  reg  [9:0]  wrIdx_reg;
  reg  [4:0]  curCnt_reg;
  reg  [4:0]  trigCnt_reg;
  reg         updStb_reg;
  reg  [11:0] raSum_reg;
  reg  [11:0] aSum_reg;
  wire [9:0]  raNewIdx;
  wire [9:0]  raOldIdx;
  wire [9:0]  aNewIdx;
  wire [9:0]  aOldIdx;

  assign raNewIdx = wrIdx_reg - {4'h0, predTicks};
  assign raOldIdx = raNewIdx - {3'h0, gateTicks};
  assign aNewIdx  = raNewIdx - `NPMC_LONG_DELAY_TICKS;
  assign aOldIdx  = raOldIdx - `NPMC_LONG_DELAY_TICKS;

  // One history slot per 100 ns tick, i.e. a 10 MHz shift rate
  always @(posedge ref_clk) begin
    if (rst || measStart) begin
      phase_reg      <= 5'h00;
      wrIdx_reg      <= 10'h000;
      curCnt_reg     <= 5'h00;
      trigCnt_reg    <= 5'h00;
      updStb_reg     <= 1'b0;
      raSum_reg      <= 12'h000;
      aSum_reg       <= 12'h000;
      gateSelLat_reg <= rst ? 2'h0 : gateSel;
      predSelLat_reg <= rst ? 3'h0 :
                        ((predelaySel > `NPMC_PREDELAY_MAX_SEL) ? `NPMC_PREDELAY_MAX_SEL
                                                                : predelaySel);
      for (hIdx = 0; hIdx < `NPMC_HIST_DEPTH; hIdx = hIdx + 1) begin
        histBuf[hIdx] <= 5'h00;
      end
    end else begin
      updStb_reg <= endTick;
      if (endTick) begin
        phase_reg          <= 5'h00;
        histBuf[wrIdx_reg] <= curCnt_reg;
        trigCnt_reg        <= curCnt_reg;
        curCnt_reg         <= 5'h00;
        wrIdx_reg          <= wrIdx_reg + 10'h001;
        raSum_reg <= raSum_reg + {7'h00, histBuf[raNewIdx]}
                               - {7'h00, histBuf[raOldIdx]};
        aSum_reg  <= aSum_reg + {7'h00, histBuf[aNewIdx]}
                              - {7'h00, histBuf[aOldIdx]};
      end else begin
        phase_reg  <= phase_reg + 5'h01;
        curCnt_reg <= curCnt_reg + {4'h0, queuePop};
      end
    end
  end

  // ----------------------------------------
  // Coincidence counters and histograms
  // ----------------------------------------
  reg  [35:0] totals_reg;
  reg  [47:0] rpaCount_reg;
  reg  [47:0] accCount_reg;
  reg  [31:0] rpaHist [0:255];
  reg  [31:0] accHist [0:255];
  wire [16:0] rpaProd;
  wire [16:0] accProd;
  wire [7:0]  raBin;
  wire [7:0]  aBin;

  assign rpaProd = trigCnt_reg * raSum_reg;
  assign accProd = trigCnt_reg * aSum_reg;
  assign raBin   = (raSum_reg > 12'h0ff) ? 8'hff : raSum_reg[7:0];
  assign aBin    = (aSum_reg > 12'h0ff) ? 8'hff : aSum_reg[7:0];

  // Every pulse in a tick sees the same gate contents; this is the dead-time trade
  always @(posedge ref_clk) begin
    if (rst || measStart) begin
      totals_reg   <= 36'h000000000;
      rpaCount_reg <= 48'h000000000000;
      accCount_reg <= 48'h000000000000;
      for (bIdx = 0; bIdx < 256; bIdx = bIdx + 1) begin
        rpaHist[bIdx] <= 32'h00000000;
        accHist[bIdx] <= 32'h00000000;
      end
    end else if (updStb_reg) begin
      totals_reg     <= totals_reg + {31'h00000000, trigCnt_reg};
      rpaCount_reg   <= rpaCount_reg + {31'h00000000, rpaProd};
      accCount_reg   <= accCount_reg + {31'h00000000, accProd};
      rpaHist[raBin] <= rpaHist[raBin] + {27'h0000000, trigCnt_reg};
      accHist[aBin]  <= accHist[aBin] + 32'h00000001;
    end
  end

  // ----------------------------------------
  // Readout sequencer
  // ----------------------------------------
  reg  [1:0]  state_reg;
  reg  [9:0]  wordIdx_reg;
  reg  [31:0] wordMux;
  wire        outInReady;
  wire        wordPush;
  wire [9:0]  rpaOff;
  wire [9:0]  accOff;

  assign wordPush = state_reg[1] & outInReady;
  assign rpaOff   = wordIdx_reg - `NPMC_WORD_RPA_HIST;
  assign accOff   = wordIdx_reg - `NPMC_WORD_ACC_HIST;

  always @* begin
    wordMux = 32'h00000000;
    if (wordIdx_reg >= `NPMC_WORD_ACC_HIST) begin
      wordMux = accHist[accOff[7:0]];
    end else if (wordIdx_reg >= `NPMC_WORD_RPA_HIST) begin
      wordMux = rpaHist[rpaOff[7:0]];
    end else begin
      case (wordIdx_reg)
        `NPMC_WORD_TOT_LO: wordMux = totals_reg[31:0];
        `NPMC_WORD_TOT_HI: wordMux = {28'h0000000, totals_reg[35:32]};
        `NPMC_WORD_RPA_LO: wordMux = rpaCount_reg[31:0];
        `NPMC_WORD_RPA_HI: wordMux = {16'h0000, rpaCount_reg[47:32]};
        `NPMC_WORD_ACC_LO: wordMux = accCount_reg[31:0];
        `NPMC_WORD_ACC_HI: wordMux = {16'h0000, accCount_reg[47:32]};
        `NPMC_WORD_STATUS: wordMux = {17'h00000, predSelLat_reg, 2'h0, gateSelLat_reg,
                                      7'h00, ovf_reg};
        default:           wordMux = 32'h00000000;
      endcase
    end
  end

  // The analyzer starts each dump; words go out in a fixed order
  always @(posedge ref_clk) begin
    if (rst || measStart) begin
      state_reg   <= ST_IDLE;
      wordIdx_reg <= 10'h000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          wordIdx_reg <= 10'h000;
          if (dumpReq) begin
            state_reg <= ST_DUMP;
          end
        end
        ST_DUMP: begin
          if (wordPush) begin
            wordIdx_reg <= wordIdx_reg + 10'h001;
            if (wordIdx_reg == `NPMC_WORD_LAST) begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Two entries let the analyzer stall without losing a word
  npmc_fifo #(
    .WIDTH (32),
    .DEPTH (`NPMC_OUT_DEPTH),
    .CW    (2)
  ) outBuf (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clr      (measStart),
    .inData   (wordMux),
    .inValid  (state_reg[1]),
    .inReady  (outInReady),
    .outData  (outData),
    .outValid (outValid),
    .outReady (outReady)
  );

  assign overflowFlag = ovf_reg;
  assign dumpBusy     = state_reg[1];

endmodule // npmc_top

// ---- hdl/npmc_defines.vh ----
// Behaviour
// - All detector channels merge into one serial pulse stream.
// - Colliding channel pulses are held and released one per clock, never overlapping.
// - Pulses 15 ns or more apart are both resolved and counted.
// - Correlation logic takes pulses only from the merger output.
// - Coincidence counting and multiplicity histogramming run in parallel on one stream.
// - Pulse history advances at 4 MHz or faster.
// - A 16-deep queue buffers the correlation input against bursts.
// - Totals counter is 36 bits; coincidence counters are 48 bits.
// - Each trigger counts pulses in reals+accidentals and accidentals gates.
// - Gate width selectable from 0.5 to 2 die-away times.
// - Predelay selectable in steps from 1 us to 5 us.
// - Accidentals gate opens at least 10 die-away times after the first.
// - Both gates keep histograms, bins 0 to 255, 32 bits each.
// - Accidentals gate is also sampled on every tick, independent of triggers.
// - Chain sustains at least two million counts per second.
// - Triples dead time stays below 100 ns, ideally below 50 ns.
// - Counters and histograms are delivered to the analyzer.
`ifndef NPMC_DEFINES_VH
`define NPMC_DEFINES_VH

// ----------------------------------------
// Clock and history timing
// ----------------------------------------
`define NPMC_NUM_CHAN          8
`define NPMC_CLK_PERIOD_NS     4
`define NPMC_TICK_NS           100
`define NPMC_TICK_CYCLES       ((`NPMC_TICK_NS) / (`NPMC_CLK_PERIOD_NS))
`define NPMC_PREDELAY_STEP_NS  1000
`define NPMC_PREDELAY_STEP_TICKS ((`NPMC_PREDELAY_STEP_NS) / (`NPMC_TICK_NS))
`define NPMC_PREDELAY_MAX_SEL  3'h4
`define NPMC_DIE_AWAY_TICKS    32
`define NPMC_LONG_DELAY_TICKS  10'h200
`define NPMC_HIST_DEPTH        1024

// ----------------------------------------
// Queue depths
// ----------------------------------------
`define NPMC_IN_DEPTH          16
`define NPMC_OUT_DEPTH         2

// ----------------------------------------
// Readout word map
// ----------------------------------------
`define NPMC_WORD_TOT_LO       10'h000
`define NPMC_WORD_TOT_HI       10'h001
`define NPMC_WORD_RPA_LO       10'h002
`define NPMC_WORD_RPA_HI       10'h003
`define NPMC_WORD_ACC_LO       10'h004
`define NPMC_WORD_ACC_HI       10'h005
`define NPMC_WORD_STATUS       10'h006
`define NPMC_WORD_RPA_HIST     10'h007
`define NPMC_WORD_ACC_HIST     10'h107
`define NPMC_WORD_LAST         10'h206
`define NPMC_STAT_OVF_BIT      0

`endif

// ---- hdl/npmc_fifo.v ----
`timescale 1ns/10ps
module npmc_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 2,
  parameter CW    = 2
) (
  input  wire             ref_clk,
  input  wire             rst,
  input  wire             clr,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);

  // ----------------------------------------
  // Shift storage: head always in entry 0
  // ----------------------------------------
  // Head stays in a flop so the output needs no read mux
  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [CW-1:0]    count_reg;
  reg              notEmpty_reg;
  reg              notFull_reg;
  wire             doPush;
  wire             doPop;
  wire [CW-1:0]    count_next;
  wire [CW-1:0]    wrIdx;
  integer          i;

  assign doPush     = inValid & notFull_reg;
  assign doPop      = outReady & notEmpty_reg;
  assign count_next = count_reg + {{(CW-1){1'b0}}, doPush} - {{(CW-1){1'b0}}, doPop};
  assign wrIdx      = doPop ? (count_reg - {{(CW-1){1'b0}}, 1'b1}) : count_reg;
  assign inReady    = notFull_reg;
  assign outValid   = notEmpty_reg;
  assign outData    = mem[0];

  always @(posedge ref_clk) begin
    if (rst || clr) begin
      count_reg    <= {CW{1'b0}};
      notEmpty_reg <= 1'b0;
      notFull_reg  <= 1'b1;
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
    end else begin
      count_reg    <= count_next;
      notEmpty_reg <= (count_next != 0);
      notFull_reg  <= (count_next != DEPTH);
      for (i = 0; i < DEPTH; i = i + 1) begin
        if (doPush && (i == wrIdx)) begin
          mem[i] <= inData;
        end else if (doPop && (i < DEPTH - 1)) begin
          mem[i] <= mem[(i == DEPTH - 1) ? i : i + 1];
        end
      end
    end
  end

endmodule // npmc_fifo

// ---- test/npmc_props.sv ----
`timescale 1ns/10ps
module npmc_props (
  input wire        ref_clk,
  input wire        rst,
  input wire        measStart,
  input wire        dumpReq,
  input wire [31:0] outData,
  input wire        outValid,
  input wire        outReady,
  input wire        overflowFlag,
  input wire        dumpBusy
);
  // --------------------
  // Words taken per dump
  // --------------------
  reg [9:0] wordCnt_reg;
  always @(posedge ref_clk) begin
    if (rst || measStart || (dumpReq && !dumpBusy)) wordCnt_reg <= 10'h000;
    else if (outValid && outReady) wordCnt_reg <= wordCnt_reg + 10'h001;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_busy; dumpReq && !dumpBusy && !measStart |=> dumpBusy; endproperty
  a_busy: assert property (p_busy)
    else $error("dump did not start");
  property p_first;
    dumpReq && !dumpBusy && !measStart ##1 !measStart |=> outValid;
  endproperty
  a_first: assert property (p_first)
    else $error("first word late");
  property p_hold; outValid && !outReady && !measStart |=> outValid && $stable(outData); endproperty
  a_hold: assert property (p_hold)
    else $error("word lost under stall");
  property p_flush; measStart && !dumpReq |=> !outValid && !dumpBusy; endproperty
  a_flush: assert property (p_flush)
    else $error("measurement start did not flush");
  property p_sticky; overflowFlag && !measStart |=> overflowFlag; endproperty
  a_sticky: assert property (p_sticky)
    else $error("overflow flag not sticky");
  // Reset itself is the cause here, so this one is not disabled by it
  property p_reset;
    disable iff (1'b0) rst |=> !outValid && !overflowFlag && !dumpBusy && outData == 32'h0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not cleared by reset");
  property p_count;
    !outValid && $past(outValid) && !$past(measStart) && !dumpBusy |-> wordCnt_reg == 10'h207;
  endproperty
  a_count: assert property (p_count)
    else $error("dump word count wrong");
  property p_cause; $rose(outValid) |-> $past(dumpBusy); endproperty
  a_cause: assert property (p_cause)
    else $error("word without dump");

  c_done: cover property ($fell(dumpBusy));
  c_stall: cover property (outValid && !outReady);
  c_ovf: cover property ($rose(overflowFlag));
  c_abort: cover property (measStart && dumpBusy);
endmodule // npmc_props

bind npmc_top npmc_props i_props (
  .ref_clk      (ref_clk),
  .rst          (rst),
  .measStart    (measStart),
  .dumpReq      (dumpReq),
  .outData      (outData),
  .outValid     (outValid),
  .outReady     (outReady),
  .overflowFlag (overflowFlag),
  .dumpBusy     (dumpBusy)
);

// ---- test/npmc_analyzer_model.sv ----
`timescale 1ns/10ps
module npmc_analyzer_model (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        measStart,
  input  wire        slowMode,
  input  wire [31:0] outData,
  input  wire        outValid,
  output reg         outReady
);
  reg [31:0] words [0:1023];
  reg [1:0]  phase_reg;
  integer    nWords;
  // Slow mode takes one word in three, so the buffer must hold its head
  always @(posedge ref_clk) begin
    if (rst) begin
      phase_reg <= 2'h0;
      outReady  <= 1'b0;
    end else begin
      phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
      outReady  <= !slowMode || (phase_reg == 2'h0);
    end
    if (rst || measStart) nWords <= 0;
    else if (outValid && outReady) begin
      words[nWords] <= outData;
      nWords <= nWords + 1;
    end
  end
endmodule // npmc_analyzer_model

// ---- test/npmc_top_bench.sv ----
`timescale 1ns/10ps
module npmc_top_bench;
  reg         ref_clk;
  reg         rst;
  reg  [7:0]  chanPulse;
  reg         measStart;
  reg  [1:0]  gateSel;
  reg  [2:0]  predelaySel;
  reg         dumpReq;
  reg         slowMode;
  wire [31:0] outData;
  wire        outValid;
  wire        outReady;
  wire        overflowFlag;
  wire        dumpBusy;
  integer     n_mismatch;
  integer     compares;
  integer     k;

  npmc_top i_dut (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .chanPulse    (chanPulse),
    .measStart    (measStart),
    .gateSel      (gateSel),
    .predelaySel  (predelaySel),
    .dumpReq      (dumpReq),
    .outData      (outData),
    .outValid     (outValid),
    .outReady     (outReady),
    .overflowFlag (overflowFlag),
    .dumpBusy     (dumpBusy)
  );
  npmc_analyzer_model i_ana (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .measStart (measStart),
    .slowMode  (slowMode),
    .outData   (outData),
    .outValid  (outValid),
    .outReady  (outReady)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ----------------
  // Shared tasks
  // ----------------
  task finish_test;
    begin
      $display("Mismatches %0d, comparisons %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp, input string what);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED at %0t: %0s got %h exp %h", $time, what, got, exp);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge ref_clk);
      #1;
    end
  endtask
  task meas(input [1:0] gs, input [2:0] ps);
    begin
      gateSel = gs;
      predelaySel = ps;
      measStart = 1'b1;
      tick(1);
      measStart = 1'b0;
    end
  endtask
  // Pulses stay high 14 cycles (56 ns) to respect the minimum width
  task fire(input [7:0] mask);
    begin
      chanPulse = mask;
      tick(14);
      chanPulse = 8'h00;
      tick(3);
    end
  endtask
  task dump(input slow);
    begin
      slowMode = slow;
      dumpReq = 1'b1;
      tick(1);
      dumpReq = 1'b0;
      for (k = 0; k < 3000 && i_ana.nWords < 519; k = k + 1) tick(1);
      chk(i_ana.nWords, 32'h207, "dump length");
      tick(4);
      chk(outValid, 32'h0, "valid after dump");
    end
  endtask

  // ----------------
  // Scenarios
  // ----------------
  task t_reset;
    begin
      chk(outValid, 32'h0, "reset valid");
      chk(overflowFlag | dumpBusy, 32'h0, "reset flags");
    end
  endtask
  // Second burst lands 17 ticks later, inside the 10..25 tick window
  task t_coinc;
    begin
      meas(2'h0, 3'h0);
      fire(8'h03);
      tick(408);
      fire(8'h1c);
      tick(750);
      dump(1'b1);
      chk(i_ana.words[0], 32'h5, "totals");
      chk(i_ana.words[1], 32'h0, "totals high");
      chk(i_ana.words[2], 32'h6, "reals plus acc");
      chk(i_ana.words[4] | i_ana.words[5], 32'h0, "acc");
      chk(i_ana.words[6], 32'h0, "status");
      chk(i_ana.words[7], 32'h2, "bin 0");
      chk(i_ana.words[9], 32'h3, "bin 2");
      chk({31'h0, i_ana.words[263] !== 32'h0}, 32'h1, "fast acc bin 0");
      for (k = 264; k < 519; k = k + 1) chk(i_ana.words[k], 32'h0, "acc bin");
    end
  endtask
  // Second channel rises 16 ns after the first while both overlap
  // A late pulse in tick 60 sees that pair only because the predelay select is clamped to 50 ticks
  task t_resolve;
    begin
      meas(2'h1, 3'h7);
      chanPulse = 8'h01;
      tick(4);
      chanPulse = 8'h03;
      tick(13);
      chanPulse = 8'h02;
      tick(4);
      chanPulse = 8'h00;
      tick(1490);
      fire(8'h10);
      tick(100);
      dump(1'b0);
      chk(i_ana.words[0], 32'h3, "close pair");
      chk(i_ana.words[2], 32'h2, "wide late gate");
      chk(i_ana.words[9], 32'h1, "bin 2 wide gate");
      chk(i_ana.words[6], 32'h4100, "latched selects");
    end
  endtask
  // Too-short pulses on all channels outrun the merger on purpose
  task t_overflow;
    begin
      meas(2'h3, 3'h1);
      repeat (40) begin
        chanPulse = 8'hff;
        tick(3);
        chanPulse = 8'h00;
        tick(2);
      end
      chk(overflowFlag, 32'h1, "overflow set");
      tick(50);
      chk(overflowFlag, 32'h1, "overflow sticky");
      dump(1'b0);
      chk(i_ana.words[6], 32'h1301, "status overflow");
      meas(2'h0, 3'h0);
      chk(overflowFlag, 32'h0, "overflow cleared");
    end
  endtask
  task t_abort;
    begin
      slowMode = 1'b1;
      dumpReq = 1'b1;
      tick(1);
      dumpReq = 1'b0;
      tick(30);
      dumpReq = 1'b1;
      tick(1);
      dumpReq = 1'b0;
      tick(30);
      chk(dumpBusy, 32'h1, "busy in dump");
      meas(2'h2, 3'h3);
      chk(outValid | dumpBusy, 32'h0, "abort flush");
      tick(5);
      dump(1'b0);
      chk(i_ana.words[6], 32'h3200, "selects latched");
    end
  endtask

  initial begin
    n_mismatch = 0;
    compares = 0;
    chanPulse = 8'h00;
    measStart = 1'b0;
    gateSel = 2'h0;
    predelaySel = 3'h0;
    dumpReq = 1'b0;
    slowMode = 1'b0;
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    t_reset;
    t_coinc;
    t_resolve;
    t_overflow;
    t_abort;
    finish_test;
  end
  // Whole run needs about 25 us
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    $display("CHECK FAILED at %0t: watchdog", $time);
    finish_test;
  end
endmodule // npmc_top_bench
